// *** logic/swrs_top.sv ***
// sleep entry, wake-up and reset cause flags with axi4-lite register access
`timescale 1ns/10ps
`include "swrs_map.svh"
module swrs_top
   import swrs_pkg::*;
#(
   parameter int WDT_CYC = `SWRS_WDT_MS * 1000 * `SWRS_CLK_MHZ,
   parameter int PIO_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins and wake sources
   input wire logic external_reset_pin_n,
   input wire logic [PIO_W-1:0] port_pin_in,
   input wire logic comparator_out,
   input wire logic watchdog_tick,
   // port drive from the core
   input wire logic [PIO_W-1:0] core_pin_out,
   input wire logic [PIO_W-1:0] core_pin_oe,
   // device side outputs
   output logic [PIO_W-1:0] port_pin_out,
   output logic [PIO_W-1:0] port_pin_oe,
   output logic core_reset,
   output logic osc_run,
   output logic external_reset_pin_oe
);
   // elaboration checks: wake pins need bit 3, the counter needs two states
   if (PIO_W < 4) begin : g_pio_chk
      $error("swrs_top: PIO_W must be at least 4");
   end
   if (WDT_CYC < 2) begin : g_wdt_chk
      $error("swrs_top: WDT_CYC must be at least 2");
   end

   localparam int WDT_W = $clog2(WDT_CYC + 1);

   swrs_state_t state_q;
   swrs_cause_t cause_q;
   logic timeout_flag_n_q, powerdown_flag_n_q, pin_wake_flag_q, comparator_wake_flag_q;
   logic [31:0] ctrl_q;
   logic [WDT_W-1:0] watchdog_counter_q;
   logic [6:0] pre_q;
   logic [2:0] latch_q;
   logic cmp_prev_q;
   logic [2:0] rst_cnt_q;
   logic pin_prev_q;
   logic [7:0] aw_addr_q;
   logic aw_have_q, w_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // write channel capture, either order
   logic wr_go;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   always_ff @(posedge clock) begin
      if (srst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // ready flops: one item held per channel
   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // write decode; unmapped writes, and command writes missing either low byte strobe, get slverr
   logic wr_ctrl, wr_cmd, wr_pin, wr_bad;
   always_comb begin
      wr_ctrl = 1'b0;
      wr_cmd = 1'b0;
      wr_pin = 1'b0;
      wr_bad = 1'b0;
      if (!wr_go) begin
         wr_bad = 1'b0;
      end else if (aw_addr_q == `SWRS_CTRL_OFS) begin
         wr_ctrl = 1'b1;
      end else if (aw_addr_q == `SWRS_CMD_OFS) begin
         wr_cmd = (w_strb_q[1:0] == 2'h3);
         wr_bad = (w_strb_q[1:0] != 2'h3);
      end else if (aw_addr_q == `SWRS_PIN_OFS) begin
         wr_pin = 1'b1;
      end else if (aw_addr_q != `SWRS_STATUS_OFS) begin
         wr_bad = 1'b1;
      end
   end

   // write response
   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_bad ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register with byte enables
   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_q <= `SWRS_CTRL_RST;
      end else if (wr_ctrl) begin
         for (int i = 0; i < 4; i++) begin
            if (w_strb_q[i]) ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
         end
      end
   end

   // decoded core events; commands are ignored while halted
   logic [11:0] op;
   logic do_sleep, do_kick, port_touch;
   assign op = w_data_q[11:0];
   assign do_sleep = wr_cmd && state_q == SWRS_RUN && op == `SWRS_OP_SLEEP
      && op[3:0] == `SWRS_OP_NIB; // see RULE9
   assign do_kick = wr_cmd && state_q == SWRS_RUN && op == `SWRS_OP_KICK;
   assign port_touch = wr_pin && state_q == SWRS_RUN;

   // watchdog on its own tick, with a 2^n prescaler
   logic wdt_en, pre_hit, wdt_expire;
   logic [2:0] pre_sel;
   assign wdt_en = ctrl_q[`SWRS_WDT_EN_BIT];
   assign pre_sel = ctrl_q[`SWRS_PRE_SHIFT +: 3];
   assign pre_hit = (pre_sel == 3'h0) || (pre_q == 7'((1 << pre_sel) - 1));
   assign wdt_expire = wdt_en && watchdog_tick && pre_hit
      && watchdog_counter_q == WDT_W'(WDT_CYC - 1);
   always_ff @(posedge clock) begin
      if (srst || state_q == SWRS_RESET || do_kick || do_sleep) begin
         watchdog_counter_q <= '0; // see RULE10, RULE17, RULE18
         pre_q <= 7'h00;
      end else if (wdt_en && watchdog_tick) begin // see RULE19
         pre_q <= pre_hit ? 7'h00 : pre_q + 7'h01;
         if (pre_hit) watchdog_counter_q <= wdt_expire ? '0 : watchdog_counter_q + 1'b1;
      end
   end

   // pin and comparator change detection
   logic [2:0] pins_now;
   logic pin_mis, cmp_chg, reset_fall;
   assign pins_now = {port_pin_in[3], port_pin_in[1], port_pin_in[0]};
   assign pin_mis = ctrl_q[`SWRS_PWAKE_EN_BIT] && pins_now != latch_q; // see RULE14, RULE15
   assign cmp_chg = ctrl_q[`SWRS_CWAKE_EN_BIT] && comparator_out != cmp_prev_q; // see RULE16
   assign reset_fall = pin_prev_q && !external_reset_pin_n;
   always_ff @(posedge clock) begin
      if (srst) begin
         latch_q <= 3'h0;
         cmp_prev_q <= 1'b0;
         pin_prev_q <= 1'b1;
      end else begin
         pin_prev_q <= external_reset_pin_n;
         // latch only refreshes on port access, so a stale mismatch survives
         if (port_touch) latch_q <= pins_now;
         if (state_q != SWRS_HALT) cmp_prev_q <= comparator_out;
      end
   end

   // state machine: run, halt, reset pulse
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= SWRS_RESET;
         cause_q <= SWRS_C_NONE;
         rst_cnt_q <= 3'h0;
      end else begin
         case (state_q)
            SWRS_RUN: begin
               rst_cnt_q <= 3'h0;
               if (wdt_expire) begin
                  state_q <= SWRS_RESET;
                  cause_q <= SWRS_C_WDT;
               end else if (reset_fall) begin
                  state_q <= SWRS_RESET;
                  cause_q <= SWRS_C_PIN;
               end else if (do_sleep) begin
                  state_q <= SWRS_HALT;
               end
            end
            SWRS_HALT: begin
               rst_cnt_q <= 3'h0;
               // any of the wake events ends halt via reset; see RULE13
               if (reset_fall || wdt_expire || pin_mis || cmp_chg) begin
                  state_q <= SWRS_RESET;
                  cause_q <= SWRS_C_NONE;
               end
            end
            SWRS_RESET: begin
               cause_q <= SWRS_C_NONE;
               if (rst_cnt_q == 3'(`SWRS_RST_PULSE_CYC - 1)) begin
                  state_q <= SWRS_RUN;
               end else begin
                  rst_cnt_q <= rst_cnt_q + 3'h1;
               end
            end
            default: state_q <= SWRS_RESET;
         endcase
      end
   end

   // reset cause flags; only reset events, halt and kick touch them
   logic halted;
   assign halted = state_q == SWRS_HALT;
   always_ff @(posedge clock) begin
      if (srst) begin
         timeout_flag_n_q <= 1'b1; // see RULE4
         powerdown_flag_n_q <= 1'b1;
         pin_wake_flag_q <= 1'b0;
         comparator_wake_flag_q <= 1'b0;
      end else if (halted && reset_fall) begin
         timeout_flag_n_q <= 1'b1; // see RULE3
         powerdown_flag_n_q <= 1'b0;
         pin_wake_flag_q <= 1'b0;
         comparator_wake_flag_q <= 1'b0;
      end else if (halted && wdt_expire) begin
         timeout_flag_n_q <= 1'b0; // see RULE1
         powerdown_flag_n_q <= 1'b0;
         pin_wake_flag_q <= 1'b0;
         comparator_wake_flag_q <= 1'b0;
      end else if (halted && (pin_mis || cmp_chg)) begin
         timeout_flag_n_q <= 1'b1; // see RULE6, RULE7
         powerdown_flag_n_q <= 1'b0;
         pin_wake_flag_q <= pin_mis;
         comparator_wake_flag_q <= !pin_mis;
      end else if (state_q == SWRS_RUN && wdt_expire) begin
         timeout_flag_n_q <= 1'b0; // see RULE2
         pin_wake_flag_q <= 1'b0;
         comparator_wake_flag_q <= 1'b0;
      end else if (state_q == SWRS_RUN && reset_fall) begin
         pin_wake_flag_q <= 1'b0; // see RULE5
         comparator_wake_flag_q <= 1'b0;
      end else if (do_sleep) begin
         timeout_flag_n_q <= 1'b1; // see RULE10
         powerdown_flag_n_q <= 1'b0; // see RULE4
      end else if (do_kick) begin
         timeout_flag_n_q <= 1'b1; // see RULE20
         powerdown_flag_n_q <= 1'b1;
      end
      // otherwise all four hold their value; see RULE8
   end

   // device outputs
   always_ff @(posedge clock) begin
      if (srst) begin
         core_reset <= 1'b1;
         osc_run <= 1'b1;
         external_reset_pin_oe <= 1'b0;
         port_pin_out <= '0;
         port_pin_oe <= '0;
      end else begin
         core_reset <= state_q == SWRS_RESET;
         osc_run <= !(halted || do_sleep); // see RULE10
         external_reset_pin_oe <= 1'b0; // see RULE12
         // frozen drive while halted; see RULE11
         if (!(halted || do_sleep)) begin
            port_pin_out <= core_pin_out;
            port_pin_oe <= core_pin_oe;
         end
      end
   end

   // read channel
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SWRS_PD_BIT] = powerdown_flag_n_q;
      status_word[`SWRS_TO_BIT] = timeout_flag_n_q;
      status_word[`SWRS_PWF_BIT] = pin_wake_flag_q;
      status_word[`SWRS_CWF_BIT] = comparator_wake_flag_q;
      status_word[`SWRS_HALT_BIT] = halted;
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_rvalid) begin
         s_axi_arready <= 1'b0;
         if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (s_axi_araddr == `SWRS_STATUS_OFS) begin
            s_axi_rdata <= status_word;
         end else if (s_axi_araddr == `SWRS_CTRL_OFS) begin
            s_axi_rdata <= ctrl_q;
         end else if (s_axi_araddr == `SWRS_CMD_OFS) begin
            s_axi_rdata <= 32'h0000_0000;
         end else if (s_axi_araddr == `SWRS_PIN_OFS) begin
            s_axi_rdata <= {29'h0, latch_q};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule // swrs_top

// *** logic/swrs_map.svh ***
// offsets, field positions, reset values and timing counts of the sleep/wake reset status block
//
// Functional notes
// RULE1 - watchdog wake clears all four flags
// RULE2 - running watchdog reset keeps powerdown, clears others
// RULE3 - reset pin wake: timeout one, rest zero
// RULE4 - power-up sets powerdown; halt clears it
// RULE5 - running pin reset clears wake flags only
// RULE6 - pin wake: pin flag, timeout set
// RULE7 - comparator wake: comparator flag, timeout set
// RULE8 - flags hold until reset; pin pulse alone inert
// RULE9 - halt only on opcode with nibble 0011
// RULE10 - halt entry: clear watchdog, timeout set, powerdown clear
// RULE11 - pins hold drive state while halted
// RULE12 - watchdog reset never pulls reset pin low
// RULE13 - four wake events cause full reset
// RULE14 - compare pins 0,1,3 with last port latch
// RULE15 - stale pin mismatch wakes immediately on halt
// RULE16 - comparator flag only on change while halted
// RULE17 - watchdog cleared on leaving halt
// RULE18 - watchdog kick clears counter and prescaler
// RULE19 - watchdog runs on its own tick while halted
// RULE20 - watchdog kick sets timeout and powerdown flags
`ifndef SWRS_MAP_SVH
`define SWRS_MAP_SVH
// register byte offsets
`define SWRS_STATUS_OFS 8'h00
`define SWRS_CTRL_OFS 8'h04
`define SWRS_CMD_OFS 8'h08
`define SWRS_PIN_OFS 8'h0C
// status field positions (flag positions match the processor status byte)
`define SWRS_PD_BIT 3
`define SWRS_TO_BIT 4
`define SWRS_PWF_BIT 5
`define SWRS_CWF_BIT 6
`define SWRS_HALT_BIT 7
// control field positions
`define SWRS_WDT_EN_BIT 0
`define SWRS_PWAKE_EN_BIT 1
`define SWRS_CWAKE_EN_BIT 2
`define SWRS_PRE_SHIFT 4
// command register: low 12 bits are an executed opcode
`define SWRS_OP_SLEEP 12'h003
`define SWRS_OP_KICK 12'h004
`define SWRS_OP_NIB 4'h3
// reset values
`define SWRS_CTRL_RST 32'h0000_0001
// timing: nominal watchdog period and a device reset pulse
`define SWRS_WDT_MS 18
`define SWRS_CLK_MHZ 50
`define SWRS_RST_PULSE_CYC 4
`endif

// *** logic/swrs_pkg.sv ***
// types of the sleep/wake reset status block
package swrs_pkg;
   typedef enum logic [2:0] {
      SWRS_RUN = 3'b001,
      SWRS_HALT = 3'b010,
      SWRS_RESET = 3'b100
   } swrs_state_t;
   typedef enum logic [2:0] {
      SWRS_C_NONE = 3'h0,
      SWRS_C_WDT = 3'h1,
      SWRS_C_PIN = 3'h2,
      SWRS_C_GPW = 3'h3,
      SWRS_C_CMW = 3'h4
   } swrs_cause_t;
endpackage

// *** tb/swrs_properties.sv ***
// concurrent checks of sleep entry, wake-up and status read-back
`timescale 1ns/10ps
`include "swrs_map.svh"
module swrs_props #(
   parameter int WDT_CYC = 4,
   parameter int PIO_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // pins and core
   input wire logic external_reset_pin_n,
   input wire logic [PIO_W-1:0] port_pin_out,
   input wire logic core_reset,
   input wire logic osc_run,
   input wire logic external_reset_pin_oe
);
   logic sleep_wr;
   logic sleep_q;
   logic st_rd;
   logic [7:0] ar_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // sleep opcode taken while running; address and data arrive together
   assign sleep_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == `SWRS_CMD_OFS && s_axi_wdata[11:0] == `SWRS_OP_SLEEP
      && s_axi_wstrb[1:0] == 2'h3 && osc_run;
   assign st_rd = s_axi_rvalid && ar_q == `SWRS_STATUS_OFS;
   // pending sleep, dropped once the oscillator stops
   always_ff @(posedge clock) begin
      if (srst || !osc_run) begin
         sleep_q <= 1'b0;
      end else if (sleep_wr) begin
         sleep_q <= 1'b1;
      end
   end
   // address of the read in flight
   always_ff @(posedge clock) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= s_axi_araddr;
      end
   end
   pin_not_driven_a: assert property (
      !external_reset_pin_oe) else $error("reset pin driven");
   sleep_enter_a: assert property (
      sleep_wr |-> ##[1:3] (!osc_run || core_reset)) else $error("sleep did not halt");
   halt_cause_a: assert property (
      $fell(osc_run) |-> sleep_q) else $error("halt without sleep opcode");
   pins_frozen_a: assert property (
      !osc_run ##1 !osc_run |-> $stable(port_pin_out)) else $error("pin drive moved");
   halt_wake_a: assert property (
      !osc_run && $fell(external_reset_pin_n) |-> ##[1:3] core_reset)
      else $error("no reset on pin wake");
   run_reset_a: assert property (
      osc_run && $fell(external_reset_pin_n) |-> ##[1:3] core_reset)
      else $error("no reset on pin press");
   reset_len_a: assert property (
      $rose(core_reset) |-> core_reset [*4] ##1 !core_reset) else $error("bad reset pulse");
   halt_flags_a: assert property (
      st_rd && s_axi_rdata[7] |-> s_axi_rdata[4:3] == 2'h2) else $error("halt flags wrong");
   one_cause_a: assert property (
      st_rd |-> !(s_axi_rdata[5] && s_axi_rdata[6])) else $error("two wake causes");
   sleep_c: cover property (sleep_wr);
   wake_c: cover property (!osc_run && $fell(external_reset_pin_n));
   cmp_flag_c: cover property (st_rd && s_axi_rdata[6]);
endmodule // swrs_props

bind swrs_top swrs_props #(.WDT_CYC(WDT_CYC), .PIO_W(PIO_W)) u_swrs_props (.clock, .srst,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .external_reset_pin_n, .port_pin_out, .core_reset, .osc_run, .external_reset_pin_oe);

// *** tb/swrs_far_side.sv ***
// far side: pulled-up reset pin, wake pins, comparator and watchdog oscillator
`timescale 1ns/10ps
module swrs_far_side #(
   parameter int TICK_DIV = 2
) (
   // bench clock and requests
   input wire logic clock,
   input wire logic tick_en,
   input wire logic press,
   input wire logic [3:0] pins_d,
   input wire logic cmp_d,
   // device pins
   output logic external_reset_pin_n,
   output logic [3:0] port_pin_in,
   output logic comparator_out,
   output logic watchdog_tick
);
   logic [7:0] div_q = 8'h00;
   logic [1:0] low_q = 2'h0;
   // own oscillator, unaffected by the core halting
   always_ff @(posedge clock) begin
      div_q <= (div_q >= TICK_DIV - 1) ? 8'h00 : div_q + 8'h01;
   end
   assign watchdog_tick = tick_en && div_q == 8'h00;
   // a press holds the pin low three cycles; the pull-up restores it
   always_ff @(posedge clock) begin
      low_q <= press ? 2'h3 : (low_q != 2'h0 ? low_q - 2'h1 : 2'h0);
   end
   assign external_reset_pin_n = low_q == 2'h0;
   assign port_pin_in = pins_d;
   assign comparator_out = cmp_d;
endmodule // swrs_far_side

// *** tb/swrs_top_bench.sv ***
// bench: register access, sleep entry and every wake-up cause
`timescale 1ns/10ps
`include "swrs_map.svh"
module swrs_top_bench;
   logic clock = 1'b0, srst = 1'b1, tick_en = 1'b0, press = 1'b0, cmp_d = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb = 4'hF, core_pin_out = 4'hA, core_pin_oe = 4'hF, pins_d = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [3:0] port_pin_in, port_pin_out, port_pin_oe;
   logic external_reset_pin_n, comparator_out, watchdog_tick, core_reset, osc_run;
   logic external_reset_pin_oe;
   int n_mismatch = 0, checked = 0;
   always #10 clock = !clock;
   swrs_top #(.WDT_CYC(4), .PIO_W(4)) u_swrs_top (.clock, .srst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_reset_pin_n,
      .port_pin_in, .comparator_out, .watchdog_tick, .core_pin_out, .core_pin_oe, .port_pin_out,
      .port_pin_oe, .core_reset, .osc_run, .external_reset_pin_oe);
   swrs_far_side u_swrs_far_side (.clock, .tick_en, .press, .pins_d, .cmp_d,
      .external_reset_pin_n, .port_pin_in, .comparator_out, .watchdog_tick);
   // verdict and end of run
   task end_of_test;
      $display("compared %0d mismatched %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait, sampled mid-cycle where registered outputs are settled
   task automatic wait_lvl(ref logic sig, input logic lvl);
      int i = 0;
      do begin
         @(negedge clock);
         i++;
      end while (sig !== lvl && i < 300);
      if (i >= 300) begin
         n_mismatch++;
         end_of_test;
      end
   endtask
   // write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      logic aw, w;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      for (int i = 0; i < 300 && (aw || w); i++) begin
         @(negedge clock);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         @(posedge clock);
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      wait_lvl(s_axi_bvalid, 1'b1);
      check("write response", s_axi_bresp, e);
      @(posedge clock);
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_lvl(s_axi_arready, 1'b1);
      @(posedge clock);
      s_axi_arvalid <= 1'b0;
      wait_lvl(s_axi_rvalid, 1'b1);
      rd_v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      s_axi_rready <= 1'b0;
   endtask
   task rd_check(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      check($sformatf("register %h", a), rd_v, e);
   endtask
   // device reset pulse seen to start and end
   task wake;
      wait_lvl(core_reset, 1'b1);
      wait_lvl(core_reset, 1'b0);
   endtask
   task push;
      @(posedge clock);
      press <= 1'b1;
      @(posedge clock);
      press <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      rd_check(`SWRS_CTRL_OFS, `SWRS_CTRL_RST);
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0018);
      wr(`SWRS_STATUS_OFS, 32'hFFFF_FFFF, 4'hF, 2'h0);
      wr(8'h40, 32'h0000_0000, 4'hF, 2'h2);
      rd(8'h40);
      check("unmapped read", resp, 2'h2);
      // sleep nibble on another opcode, and a half-strobed sleep
      wr(`SWRS_CMD_OFS, 32'h0000_0013, 4'hF, 2'h0);
      wr(`SWRS_CMD_OFS, 32'h0000_0003, 4'h1, 2'h2);
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0018);
      wr(`SWRS_CMD_OFS, 32'h0000_0003, 4'hF, 2'h0);
      core_pin_out <= 4'h5;
      core_pin_oe <= 4'h3;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0090);
      check("oscillator", osc_run, 1'b0);
      check("pin drive", port_pin_out, 4'hA);
      check("pin enable", port_pin_oe, 4'hF);
      push;
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0010);
      check("oscillator", osc_run, 1'b1);
      check("pin drive", port_pin_out, 4'h5);
      check("pin enable", port_pin_oe, 4'h3);
      check("reset pin oe", external_reset_pin_oe, 1'b0);
      wr(`SWRS_CMD_OFS, 32'h0000_0004, 4'hF, 2'h0);
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0018);
      // pin wake, then a halt with the mismatch still pending
      wr(`SWRS_CTRL_OFS, 32'h0000_0002, 4'hF, 2'h0);
      wr(`SWRS_PIN_OFS, 32'h0000_0000, 4'hF, 2'h0);
      wr(`SWRS_CMD_OFS, 32'h0000_0003, 4'hF, 2'h0);
      pins_d <= 4'h1;
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0030);
      wr(`SWRS_CMD_OFS, 32'h0000_0003, 4'hF, 2'h0);
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0030);
      push;
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0010);
      // pin 2 alone must not wake; the comparator then does
      wr(`SWRS_CTRL_OFS, 32'h0000_0006, 4'hF, 2'h0);
      wr(`SWRS_PIN_OFS, 32'h0000_0000, 4'hF, 2'h0);
      wr(`SWRS_CMD_OFS, 32'h0000_0003, 4'hF, 2'h0);
      pins_d <= 4'h5;
      repeat (20) @(posedge clock);
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0090);
      cmp_d <= 1'b1;
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0050);
      // a comparator change while running must neither wake nor flag
      cmp_d <= 1'b0;
      repeat (4) @(posedge clock);
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0050);
      // watchdog at prescale 8: wake, kicks hold it off, then it expires
      wr(`SWRS_CTRL_OFS, 32'h0000_0031, 4'hF, 2'h0);
      tick_en <= 1'b1;
      wr(`SWRS_CMD_OFS, 32'h0000_0003, 4'hF, 2'h0);
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0000);
      repeat (4) begin
         wr(`SWRS_CMD_OFS, 32'h0000_0004, 4'hF, 2'h0);
         repeat (15) @(posedge clock);
      end
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0018);
      wake;
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0008);
      // second power-up in mid-run restores the power-up flags
      tick_en <= 1'b0;
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rd_check(`SWRS_CTRL_OFS, `SWRS_CTRL_RST);
      rd_check(`SWRS_STATUS_OFS, 32'h0000_0018);
      end_of_test;
   end
endmodule // swrs_top_bench
